// ==== rtl/process_image_map.vh ====
// constants for the fieldbus process image
`ifndef PROCESS_IMAGE_MAP_VH
`define PROCESS_IMAGE_MAP_VH
// ==========================================
// sizes
`define STATUS_BITS        96
`define ONOFF_BITS         64
`define RCD_BITS           16
`define CODE_BITS          16
`define LOG_ENTRIES        10
`define ENTRY_WORDS        15
`define NAME_WORDS         6
// ==========================================
// word offsets within an entry
`define W_TIME_LO          4'h0
`define W_TIME_HI          4'h1
`define W_LEN_LO           4'h2
`define W_LEN_HI           4'h3
`define W_NAME0            4'h4
`define W_ERR              4'ha
`define W_ADV              4'hb
`define W_INDEX            4'hc
`define W_RSV0             4'hd
`define W_RSV1             4'he
// ==========================================
// timing
`define CLK_HZ             50000000
`define SECOND_CYCLES      (`CLK_HZ / 1)
// last divider count of one second, sized to the 26-bit divider
`define SECOND_LAST        26'h2fa_f07f
`define CODE_SCALE         16'h0064
`endif

// ==== rtl/fault_entry_reg.v ====
// one fault log entry store with shift-in
`timescale 1ns/100ps
`default_nettype none
`include "process_image_map.vh"
module fault_entry_reg (
	input  wire         ref_clk,
	input  wire         reset_n,
	input  wire         load,
	input  wire [31:0]  time_in,
	input  wire [3:0]   len_in,
	input  wire [95:0]  name_in,
	input  wire [15:0]  err_in,
	input  wire [15:0]  adv_in,
	input  wire [15:0]  index_in,
	output reg  [31:0]  time_reg,
	output reg  [3:0]   len_reg,
	output reg  [95:0]  name_reg,
	output reg  [15:0]  err_reg,
	output reg  [15:0]  adv_reg,
	output reg  [15:0]  index_reg
);
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			time_reg  <= 32'h0000_0000;
			len_reg   <= 4'h0;
			name_reg  <= 96'h0000_0000_0000_0000_0000_0000;
			err_reg   <= 16'h0000;
			adv_reg   <= 16'h0000;
			index_reg <= 16'h0000;
		end else if (load) begin
			time_reg  <= time_in;
			len_reg   <= len_in;
			name_reg  <= name_in;
			err_reg   <= err_in;
			adv_reg   <= adv_in;
			index_reg <= index_in;
		end
	end
endmodule // fault_entry_reg
`default_nettype wire

// ==== rtl/fieldbus_process_image.v ====
// cyclic process image between safety logic and fieldbus controller
`timescale 1ns/100ps
`default_nettype none
`include "process_image_map.vh"
module fieldbus_process_image (
	input  wire         ref_clk,
	input  wire         reset_n,
	input  wire         exchange_tick,
	input  wire [95:0]  output_status_in,
	input  wire [63:0]  onoff_bytes_in,
	input  wire [15:0]  rcd_bytes_in,
	input  wire [15:0]  actuation_code_in,
	input  wire         rcd_sequence_active,
	input  wire [15:0]  rcd_feedback_in,
	input  wire [15:0]  code_feedback_in,
	input  wire         fault_log_enable,
	input  wire         fault_valid,
	input  wire [7:0]   fault_err_code,
	input  wire [7:0]   fault_adv_code,
	input  wire [3:0]   fault_name_len,
	input  wire [95:0]  fault_name,
	input  wire [3:0]   log_entry_sel,
	input  wire [3:0]   log_word_sel,
	output reg  [95:0]  output_status_image,
	output reg  [63:0]  onoff_mute_enable_bits,
	output reg  [15:0]  virtual_reset_cancel_delay_bits,
	output reg  [15:0]  actuation_code,
	output reg  [15:0]  rcd_feedback_image,
	output reg  [15:0]  code_feedback_image,
	output reg  [31:0]  seconds_since_power_up,
	output reg  [15:0]  log_word
);
	// ==========================================
	// seconds since power-up
	reg  [25:0] sec_div_reg;
	wire        sec_tick;
	assign sec_tick = (sec_div_reg == `SECOND_LAST);
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sec_div_reg <= 26'h000_0000;
		end else begin
			sec_div_reg <= sec_tick ? 26'h000_0000 : sec_div_reg + 26'h000_0001;
		end
	end
	// the count wraps only after about 136 years of uptime
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			seconds_since_power_up <= 32'h0000_0000;
		end else if (sec_tick) begin
			seconds_since_power_up <= seconds_since_power_up + 32'h0000_0001;
		end
	end

	// ==========================================
	// cyclic exchange: inputs refreshed, outputs latched at one boundary
	// bit n of each vector sits in byte n/8, bit n%8, so byte order falls out of the packing
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			output_status_image <= 96'h0000_0000_0000_0000_0000_0000;
		end else if (exchange_tick) begin
			output_status_image <= output_status_in;
		end
	end
	// controller-written on/off and mute enable slot
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			onoff_mute_enable_bits <= 64'h0000_0000_0000_0000;
		end else if (exchange_tick) begin
			onoff_mute_enable_bits <= onoff_bytes_in;
		end
	end
	// request bits and code only pass while a sequence runs, so stale writes act on nothing
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			virtual_reset_cancel_delay_bits <= 16'h0000;
			actuation_code                  <= 16'h0000;
		end else if (exchange_tick) begin
			virtual_reset_cancel_delay_bits <= rcd_sequence_active ? rcd_bytes_in : 16'h0000;
			actuation_code                  <= rcd_sequence_active ? actuation_code_in : 16'h0000;
		end
	end
	// feedback slots
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rcd_feedback_image  <= 16'h0000;
			code_feedback_image <= 16'h0000;
		end else if (exchange_tick) begin
			rcd_feedback_image  <= rcd_feedback_in;
			code_feedback_image <= code_feedback_in;
		end
	end

	// ==========================================
	// new entry fields
	wire [15:0] err_w;
	wire [15:0] adv_w;
	wire [15:0] index_w;
	wire [95:0] name_mask;
	wire [3:0]  len_w;
	assign err_w   = {8'h00, fault_err_code};
	assign adv_w   = {8'h00, fault_adv_code};
	// minor part below 100 keeps its two-digit zero padding automatically
	wire [31:0] index_full;
	assign index_full = err_w * `CODE_SCALE + adv_w;
	assign index_w    = index_full[15:0];
	assign len_w   = (fault_name_len > 4'hc) ? 4'hc : fault_name_len;
	genvar c;
	generate
		for (c = 0; c < 12; c = c + 1) begin : g_mask
			assign name_mask[c*8 +: 8] = (c < len_w) ? 8'hff : 8'h00;
		end
	endgenerate
	// ==========================================
	// log chain: entry 0 newest, entry 9 oldest; oldest falls off
	wire        push;
	wire [31:0] t_d   [0:`LOG_ENTRIES-1];
	wire [3:0]  l_d   [0:`LOG_ENTRIES-1];
	wire [95:0] n_d   [0:`LOG_ENTRIES-1];
	wire [15:0] e_d   [0:`LOG_ENTRIES-1];
	wire [15:0] a_d   [0:`LOG_ENTRIES-1];
	wire [15:0] i_d   [0:`LOG_ENTRIES-1];
	wire [31:0] t_q   [0:`LOG_ENTRIES-1];
	wire [3:0]  l_q   [0:`LOG_ENTRIES-1];
	wire [95:0] n_q   [0:`LOG_ENTRIES-1];
	wire [15:0] e_q   [0:`LOG_ENTRIES-1];
	wire [15:0] a_q   [0:`LOG_ENTRIES-1];
	wire [15:0] i_q   [0:`LOG_ENTRIES-1];
	assign push = fault_log_enable & fault_valid;
	// all entries load on the same push, so the shift takes one cycle whatever the depth
	genvar k;
	generate
		for (k = 0; k < `LOG_ENTRIES; k = k + 1) begin : g_entry
			if (k == 0) begin : g_head
				assign t_d[k] = seconds_since_power_up;
				assign l_d[k] = len_w;
				assign n_d[k] = fault_name & name_mask;
				assign e_d[k] = err_w;
				assign a_d[k] = adv_w;
				assign i_d[k] = index_w;
			end else begin : g_tail
				assign t_d[k] = t_q[k-1];
				assign l_d[k] = l_q[k-1];
				assign n_d[k] = n_q[k-1];
				assign e_d[k] = e_q[k-1];
				assign a_d[k] = a_q[k-1];
				assign i_d[k] = i_q[k-1];
			end
			fault_entry_reg u_entry (
				.ref_clk   (ref_clk),
				.reset_n   (reset_n),
				.load      (push),
				.time_in   (t_d[k]),
				.len_in    (l_d[k]),
				.name_in   (n_d[k]),
				.err_in    (e_d[k]),
				.adv_in    (a_d[k]),
				.index_in  (i_d[k]),
				.time_reg  (t_q[k]),
				.len_reg   (l_q[k]),
				.name_reg  (n_q[k]),
				.err_reg   (e_q[k]),
				.adv_reg   (a_q[k]),
				.index_reg (i_q[k])
			);
		end
	endgenerate

	// ==========================================
	// log read port: entry_sel 0 is entry one (newest)
	reg        sel_ok;
	reg [3:0]  ent;
	reg [31:0] sel_time;
	reg [3:0]  sel_len;
	reg [95:0] sel_name;
	reg [15:0] sel_err;
	reg [15:0] sel_adv;
	reg [15:0] sel_index;
	reg [15:0] word_next;
	// out-of-range selects fall back to entry one so the index never leaves the array
	always @* begin
		sel_ok    = fault_log_enable && (log_entry_sel < 4'ha);
		ent       = sel_ok ? log_entry_sel : 4'h0;
		sel_time  = t_q[ent];
		sel_len   = l_q[ent];
		sel_name  = n_q[ent];
		sel_err   = e_q[ent];
		sel_adv   = a_q[ent];
		sel_index = i_q[ent];
	end
	always @* begin
		word_next = 16'h0000;
		if (sel_ok) begin
			case (log_word_sel)
				`W_TIME_LO: word_next = sel_time[15:0];
				`W_TIME_HI: word_next = sel_time[31:16];
				`W_LEN_LO:  word_next = {12'h000, sel_len};
				`W_LEN_HI:  word_next = 16'h0000;
				4'h4:       word_next = sel_name[15:0];
				4'h5:       word_next = sel_name[31:16];
				4'h6:       word_next = sel_name[47:32];
				4'h7:       word_next = sel_name[63:48];
				4'h8:       word_next = sel_name[79:64];
				4'h9:       word_next = sel_name[95:80];
				`W_ERR:     word_next = sel_err;
				`W_ADV:     word_next = sel_adv;
				`W_INDEX:   word_next = sel_index;
				default:    word_next = 16'h0000;
			endcase
		end
	end
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			log_word <= 16'h0000;
		else
			log_word <= word_next;
	end
endmodule // fieldbus_process_image
`default_nettype wire

// ==== dv/process_image_checker_assertions.sv ====
// concurrent checks on the process image ports
`timescale 1ns/100ps
`default_nettype none
module process_image_checker (
	input wire logic        ref_clk, reset_n, exchange_tick, rcd_sequence_active, fault_log_enable,
	input wire logic [95:0] output_status_in, output_status_image,
	input wire logic [63:0] onoff_bytes_in, onoff_mute_enable_bits,
	input wire logic [15:0] rcd_bytes_in, actuation_code_in, rcd_feedback_in, code_feedback_in,
	input wire logic [15:0] virtual_reset_cancel_delay_bits, actuation_code, log_word,
	input wire logic [15:0] rcd_feedback_image, code_feedback_image,
	input wire logic [31:0] seconds_since_power_up,
	input wire logic [3:0]  log_entry_sel, log_word_sel
);
	// ==========
	// slot latching and log reads
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_status_latch: assert property (exchange_tick |=> output_status_image == $past(output_status_in))
		else $error("status image");
	a_status_hold: assert property (!exchange_tick |=> $stable(output_status_image))
		else $error("status hold");
	a_onoff_latch: assert property (exchange_tick |=> onoff_mute_enable_bits == $past(onoff_bytes_in))
		else $error("onoff image");
	a_request_gate: assert property (exchange_tick && !rcd_sequence_active |=>
		{virtual_reset_cancel_delay_bits, actuation_code} == 32'h0000_0000) else $error("request gate");
	a_request_pass: assert property (exchange_tick && rcd_sequence_active |=>
		{virtual_reset_cancel_delay_bits, actuation_code} == $past({rcd_bytes_in, actuation_code_in}))
		else $error("request pass");
	a_feedback_latch: assert property (exchange_tick |=>
		{rcd_feedback_image, code_feedback_image} == $past({rcd_feedback_in, code_feedback_in}))
		else $error("feedback");
	a_log_off: assert property (!fault_log_enable |=> log_word == 16'h0000) else $error("log off");
	a_entry_range: assert property (log_entry_sel > 4'h9 |=> log_word == 16'h0000) else $error("range");
	a_reserved_zero: assert property (log_word_sel == 4'h3 || log_word_sel == 4'hd || log_word_sel == 4'he
		|=> log_word == 16'h0000) else $error("reserved");
	// one second is far beyond the run, so only a step of at most one is checked
	a_seconds_step: assert property (1 |=>
		seconds_since_power_up - $past(seconds_since_power_up) <= 32'h0000_0001) else $error("seconds");
	c_sequence: cover property (exchange_tick && rcd_sequence_active);
	c_log_read: cover property (fault_log_enable && log_word != 16'h0000);
	c_oldest: cover property (log_entry_sel == 4'h9 && fault_log_enable);
endmodule // process_image_checker
bind fieldbus_process_image process_image_checker i_chk (.*);
`default_nettype wire

// ==== dv/plc_model.sv ====
// controller side model writing its slots each exchange cycle
`timescale 1ns/100ps
`default_nettype none
module plc_model (
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        exchange_tick,
	output wire logic [63:0] onoff_bytes_in,
	output wire logic [15:0] rcd_bytes_in,
	output wire logic [15:0] actuation_code_in
);
	// ==========
	// fresh data every exchange, so a stale latch shows up
	logic [15:0] step_reg;
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) step_reg <= 16'h0000;
		else if (exchange_tick) step_reg <= step_reg + 16'h0001;
	end
	assign onoff_bytes_in = {step_reg, ~step_reg, step_reg ^ 16'ha5a5, 16'h0180};
	assign rcd_bytes_in = ~step_reg ^ 16'h00ff;
	assign actuation_code_in = step_reg ^ 16'h5a3c;
endmodule // plc_model
`default_nettype wire

// ==== dv/fieldbus_process_image_tb_top.sv ====
// self-checking bench for the fieldbus process image
`timescale 1ns/100ps
`default_nettype none
`include "process_image_map.vh"
module fieldbus_process_image_tb_top;
	logic ref_clk = 0, reset_n = 0, exchange_tick = 0, rcd_sequence_active = 0, fault_log_enable = 0;
	logic fault_valid = 0;
	logic [95:0] output_status_in = '0, fault_name = '0, exp;
	logic [15:0] rcd_feedback_in = '0, code_feedback_in = '0;
	logic [7:0]  fault_err_code = '0, fault_adv_code = '0;
	logic [3:0]  fault_name_len = '0, log_entry_sel = '0, log_word_sel = '0;
	wire [95:0]  output_status_image;
	wire [63:0]  onoff_bytes_in, onoff_mute_enable_bits;
	wire [15:0]  rcd_bytes_in, actuation_code_in, virtual_reset_cancel_delay_bits, actuation_code;
	wire [15:0]  rcd_feedback_image, code_feedback_image, log_word;
	wire [31:0]  seconds_since_power_up;
	int err_total = 0, samples_checked = 0, i;
	always #10 ref_clk = ~ref_clk;
	fieldbus_process_image i_dut (.*);
	plc_model i_plc (.*);
	// ==========
	// access tasks
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic do_tick;
		exchange_tick = 1;
		step(1);
		exchange_tick = 0;
		step(1);
	endtask
	task automatic do_fault(input logic [7:0] e, input logic [7:0] a);
		{fault_err_code, fault_adv_code, fault_valid} = {e, a, 1'b1};
		step(1);
		fault_valid = 0;
		step(1);
	endtask
	task automatic rd(input logic [3:0] e, input logic [3:0] w, input logic [15:0] x);
		{log_entry_sel, log_word_sel} = {e, w};
		step(2);
		chk("log_word", x, log_word);
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#1ms;
		err_total++;
		test_done;
	end
	// ==========
	// main sequence
	initial begin
		step(5);
		reset_n = 1;
		step(1);
		chk("seconds", 0, seconds_since_power_up);
		{output_status_in, rcd_feedback_in, code_feedback_in} = {96'h0b0a_0908_0706_0504_0302_0100, 32'hc33c_1234};
		exp = onoff_bytes_in;
		do_tick;
		chk("status", 96'h0b0a_0908_0706_0504_0302_0100, output_status_image);
		chk("onoff", exp, onoff_mute_enable_bits);
		chk("request off", 0, {virtual_reset_cancel_delay_bits, actuation_code});
		chk("feedback", 32'hc33c_1234, {rcd_feedback_image, code_feedback_image});
		rcd_sequence_active = 1;
		exp = {rcd_bytes_in, actuation_code_in};
		do_tick;
		chk("request on", exp, {virtual_reset_cancel_delay_bits, actuation_code});
		output_status_in = '0;
		step(3);
		chk("hold", 96'h0b0a_0908_0706_0504_0302_0100, output_status_image);
		// eleven faults into ten places: the first must fall out
		{fault_log_enable, fault_name_len, fault_name} = {1'b1, 4'h3, 96'h4847_4645_4443_4241};
		for (i = 0; i < 11; i++) do_fault(i + 1, i);
		for (i = 0; i < 10; i++) begin
			rd(i, `W_ERR, 11 - i);
			rd(i, `W_ADV, 10 - i);
			rd(i, `W_INDEX, (11 - i) * 100 + 10 - i);
		end
		rd(0, `W_TIME_LO, 0);
		rd(0, `W_LEN_LO, 3);
		rd(0, `W_NAME0, 16'h4241);
		rd(0, `W_NAME0 + 4'h1, 16'h0043);
		rd(0, `W_RSV1, 0);
		rd(4'ha, `W_ERR, 0);
		fault_log_enable = 0;
		do_fault(8'h07, 8'h07);
		rd(0, `W_ERR, 0);
		fault_log_enable = 1;
		rd(0, `W_ERR, 11);
		test_done;
	end
endmodule // fieldbus_process_image_tb_top
`default_nettype wire
